// ### design/lnk_pkg.sv
// Operation
// [RQ1] Master moves up to 1024 points each way
// [RQ2] Slave exchanges 32 or 64 points
// [RQ3] Master sends all outputs as one frame
// [RQ4] Slaves served in chain position order
// [RQ5] Slave takes its share, forwards rest
// [RQ6] Master polls returns continuously while running
// [RQ7] Input slot fixed by chain position
// [RQ8] Images freeze on any disruption
// [RQ9] Recovery zeroes images, then updates them
// [RQ10] Fault stops traffic at faulty point
// [RQ11] Master tolerates size, stop, order mismatches
// [RQ12] Mixed chain: any fault stops link
// [RQ13] Host restart recovers from full shutdown
// [RQ14] Invalid configuration blocks start, flagged
// [RQ15] Separate differential transmit and receive pairs
// [RQ16] Bit rate at most 1.5 Mbaud
// [RQ17] Host selects master or slave
// [RQ18] Host gates input and output updates
// [RQ19] Host starts, restarts, resets, stops link
// [RQ20] Status shows ok, receiving, link fault
// [RQ21] Receiving flag drops after return timeout
package lnk_pkg;
    localparam int CLK_HZ     = 40000000;
    localparam int BAUD_MAX   = 1500000;
    // Least bit time rounds up so the rate never exceeds the limit
    localparam int BIT_CYC    = (CLK_HZ + BAUD_MAX - 1) / BAUD_MAX;
    localparam int GAP_BITS   = 20;
    localparam int GAP_CYC    = GAP_BITS * BIT_CYC;
    localparam int TMO_US     = 1000;
    localparam int TMO_CYC    = TMO_US * (CLK_HZ / 1000000);
    localparam int MAX_POINTS = 1024;
    localparam int MAX_BYTES  = MAX_POINTS / 8;
    localparam int SLV_PTS_LO = 32;
    localparam int SLV_PTS_HI = 64;
    localparam int BCW        = 5;
    localparam int ICW        = 10;
    localparam int TCW        = 24;

    localparam logic [BCW-1:0] BIT_CNT  = BCW'(BIT_CYC - 1);
    localparam logic [BCW-1:0] HALF_CNT = BCW'(BIT_CYC / 2 - 1);
    localparam logic [ICW-1:0] GAP_CNT  = ICW'(GAP_CYC);
    localparam logic [7:0]     MAX_LEN  = 8'(MAX_BYTES);
    localparam logic [7:0]     SLV_B_LO = 8'(SLV_PTS_LO / 8);
    localparam logic [7:0]     SLV_B_HI = 8'(SLV_PTS_HI / 8);

    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_CFG  = 8'h01;
    localparam logic [7:0] A_LEN  = 8'h02;
    localparam logic [7:0] A_TMO  = 8'h03;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [2:0] W_OUT  = 3'h2;
    localparam logic [2:0] W_IN   = 3'h4;

    localparam int CTRL_START = 0;
    localparam int CTRL_STOP  = 1;
    localparam int CFG_MASTER = 0;
    localparam int CFG_SIZE64 = 1;
    localparam int CFG_IN_EN  = 2;
    localparam int CFG_OUT_EN = 3;
    localparam int CFG_STRICT = 4;
    localparam int LEN_OUT    = 0;
    localparam int LEN_IN     = 8;
    localparam logic [4:0] CFG_RST = 5'h0c;
    localparam logic [7:0] LEN_RST = 8'h80;

    typedef struct packed {
        logic       vld;
        logic       fend;
        logic [7:0] data;
    } rx_s;

    typedef struct packed {
        logic       strict;
        logic       out_en;
        logic       in_en;
        logic       size64;
        logic       master;
        logic [7:0] in_len;
        logic [7:0] out_len;
    } cfg_s;

    typedef enum logic [3:0] {
        L_IDLE = 4'b0001,
        L_SEND = 4'b0010,
        L_WAIT = 4'b0100,
        L_RET  = 4'b1000
    } lstate_e;
endpackage

// ### design/io_link_engine.sv
module io_link_engine
    import lnk_pkg::*;
#(
    parameter int TMO_DEF = TMO_CYC
) (
    input  wire logic        mclk,     // System clock, 40 MHz
    input  wire logic        rst_b,    // Asynchronous reset, active low
    input  wire logic [7:0]  addr,     // Register word index
    input  wire logic [31:0] wdata,    // Write data
    input  wire logic        wr,       // Write strobe
    input  wire logic        rd,       // Read strobe
    output logic      [31:0] rdata,    // Read data, cycle after rd
    input  wire logic        up_rx_p,  // Upper port receive pair, true
    input  wire logic        up_rx_n,  // Upper port receive pair, complement
    output logic             up_tx_p,  // Upper port transmit pair, true
    output logic             up_tx_n,  // Upper port transmit pair, complement
    input  wire logic        dn_rx_p,  // Lower port receive pair, true
    input  wire logic        dn_rx_n,  // Lower port receive pair, complement
    output logic             dn_tx_p,  // Lower port transmit pair, true
    output logic             dn_tx_n   // Lower port transmit pair, complement
);
    localparam int BITD = BIT_CYC - 1;

    function automatic logic [7:0] lane(input logic [31:0] w, input logic [1:0] l);
        lane = w[8*l +: 8];
    endfunction

    // Channel 0 is the upper port, channel 1 the lower port
    logic [1:0] sp1, sp2, sn1, sn2, line;
    logic [1:0] txo, txon, tx_busy, tx_go;
    logic [7:0] tx_data [2];
    rx_s        rxo [2];

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sp1 <= 2'h3;
            sp2 <= 2'h3;
            sn1 <= 2'h0;
            sn2 <= 2'h0;
        end else begin
            sp1 <= {dn_rx_p, up_rx_p};
            sp2 <= sp1;
            sn1 <= {dn_rx_n, up_rx_n};
            sn2 <= sn1;
        end
    end

    // A pair with both legs equal is a dead line and reads as idle
    assign line = (sp2 ^ sn2) & sp2 | ~(sp2 ^ sn2);

    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_ch
            logic           rbusy, next_rbusy, seen, next_seen;
            logic [BCW-1:0] rcnt, next_rcnt, tcnt, next_tcnt;
            logic [3:0]     rbit, next_rbit, tbit, next_tbit;
            logic [7:0]     rsh, next_rsh;
            logic [ICW-1:0] idle, next_idle;
            rx_s            rout, next_rout;
            logic           tbusy, next_tbusy;
            logic [9:0]     tsh, next_tsh;
            logic           tq, tqn;

            always_comb begin
                next_rbusy = rbusy;
                next_rcnt  = rcnt;
                next_rbit  = rbit;
                next_rsh   = rsh;
                next_idle  = idle;
                next_seen  = seen;
                next_rout  = '0;
                if (!rbusy) begin
                    if (!line[c]) begin
                        next_rbusy = 1'b1;
                        next_rcnt  = HALF_CNT;
                        next_rbit  = 4'h0;
                        next_idle  = '0;
                    end else if (idle < GAP_CNT) begin
                        next_idle = idle + 1'b1;
                    end else if (seen) begin
                        // Frame ends after a quiet gap following at least one byte
                        next_rout.fend = 1'b1;
                        next_seen      = 1'b0;
                    end
                end else if (rcnt != '0) begin
                    next_rcnt = rcnt - 1'b1;
                end else begin
                    next_rcnt = BIT_CNT;
                    next_rbit = rbit + 1'b1;
                    if (rbit == 4'h0 && line[c]) begin
                        next_rbusy = 1'b0;
                    end else if (rbit >= 4'h1 && rbit <= 4'h8) begin
                        next_rsh = {line[c], rsh[7:1]};
                    end else if (rbit == 4'h9) begin
                        next_rbusy     = 1'b0;
                        next_rout.vld  = line[c];
                        next_rout.data = rsh;
                        next_seen      = seen | line[c];
                    end
                end
            end

            // [RQ16] bit period never below limit
            always_comb begin
                next_tbusy = tbusy;
                next_tcnt  = tcnt;
                next_tbit  = tbit;
                next_tsh   = tsh;
                if (!tbusy && tx_go[c]) begin
                    next_tbusy = 1'b1;
                    next_tsh   = {1'b1, tx_data[c], 1'b0};
                    next_tcnt  = BIT_CNT;
                    next_tbit  = 4'h0;
                end else if (tbusy) begin
                    if (tcnt != '0) begin
                        next_tcnt = tcnt - 1'b1;
                    end else begin
                        next_tcnt = BIT_CNT;
                        next_tsh  = {1'b1, tsh[9:1]};
                        next_tbit = tbit + 1'b1;
                        if (tbit == 4'h9) begin
                            next_tbusy = 1'b0;
                        end
                    end
                end
            end

            always_ff @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    rbusy   <= 1'b0;
                    rcnt    <= '0;
                    rbit    <= 4'h0;
                    rsh     <= 8'h00;
                    idle    <= '0;
                    seen    <= 1'b0;
                    rout    <= '0;
                    tbusy   <= 1'b0;
                    tcnt    <= '0;
                    tbit    <= 4'h0;
                    tsh     <= 10'h3ff;
                    tq      <= 1'b1;
                    tqn     <= 1'b0;
                end else begin
                    rbusy   <= next_rbusy;
                    rcnt    <= next_rcnt;
                    rbit    <= next_rbit;
                    rsh     <= next_rsh;
                    idle    <= next_idle;
                    seen    <= next_seen;
                    rout    <= next_rout;
                    tbusy   <= next_tbusy;
                    tcnt    <= next_tcnt;
                    tbit    <= next_tbit;
                    tsh     <= next_tsh;
                    // [RQ15] complementary drive
                    tq      <= next_tbusy ? next_tsh[0] : 1'b1;
                    tqn     <= next_tbusy ? ~next_tsh[0] : 1'b0;
                end
            end

            assign rxo[c]     = rout;
            assign tx_busy[c] = tbusy;
            assign txo[c]     = tq;
            assign txon[c]    = tqn;
        end
    endgenerate

    assign up_tx_p = txo[0];
    assign up_tx_n = txon[0];
    assign dn_tx_p = txo[1];
    assign dn_tx_n = txon[1];

    // Link control and host registers
    logic [31:0]    out_img [32];
    logic [31:0]    in_img [32];
    cfg_s           cfg, next_cfg;
    lstate_e        st, next_st;
    logic [TCW-1:0] tmo, next_tmo, wcnt, next_wcnt;
    logic [7:0]     bidx, next_bidx, ridx, next_ridx, nb;
    logic           running, next_running, cfg_bad, next_cfg_bad, cfg_set, next_cfg_set;
    logic           fault, next_fault, rx_act, next_rx_act, recover, next_recover;
    logic           zero_tx, next_zero_tx, fpend, next_fpend, rpend, next_rpend;
    logic [7:0]     fbyte, next_fbyte, rbyte, next_rbyte;
    logic [31:0]    next_rdata;
    logic           in_clr, in_we, fwd_set, tmo_hit, cfg_ok, start, stop;
    logic [6:0]     in_idx;
    logic [7:0]     in_byte;

    // [RQ2] slave share
    assign nb     = cfg.size64 ? SLV_B_HI : SLV_B_LO;
    // [RQ1] [RQ14] master lengths within the maximum image
    assign cfg_ok = cfg_set && (!cfg.master ||
                    (cfg.out_len != 8'h00 && cfg.out_len <= MAX_LEN && cfg.in_len <= MAX_LEN));
    assign start  = wr && addr == A_CTRL && wdata[CTRL_START];
    assign stop   = wr && addr == A_CTRL && wdata[CTRL_STOP];

    always_comb begin
        next_cfg     = cfg;
        next_st      = st;
        next_tmo     = tmo;
        next_wcnt    = wcnt;
        next_bidx    = bidx;
        next_ridx    = ridx;
        next_running = running;
        next_cfg_bad = cfg_bad;
        next_cfg_set = cfg_set;
        next_fault   = fault;
        next_rx_act  = rx_act;
        next_recover = recover;
        next_zero_tx = zero_tx;
        next_fpend   = fpend;
        next_fbyte   = fbyte;
        next_rpend   = rpend;
        next_rbyte   = rbyte;
        tx_go        = 2'b00;
        tx_data[0]   = 8'h00;
        tx_data[1]   = fbyte;
        in_clr       = 1'b0;
        in_we        = 1'b0;
        in_idx       = ridx[6:0];
        in_byte      = rxo[0].data;
        fwd_set      = 1'b0;
        tmo_hit      = 1'b0;

        if (running && st == L_WAIT) begin
            next_wcnt = wcnt + 1'b1;
            // [RQ21] no valid return within the timeout
            if (wcnt >= tmo) begin
                tmo_hit      = 1'b1;
                next_wcnt    = '0;
                next_rx_act  = 1'b0;
                next_fault   = 1'b1;
                next_recover = 1'b1;
                // [RQ11] [RQ6] outside strict mode a silent slave never stalls polling
                if (cfg.master) begin
                    next_st   = L_SEND;
                    next_bidx = 8'h00;
                end
            end
            if (rxo[0].vld) begin
                if (ridx != 8'hff) begin
                    next_ridx = ridx + 1'b1;
                end
                // [RQ9] clear first, then this frame overwrites
                if (ridx == 8'h00 && recover) begin
                    in_clr = 1'b1;
                end
                // [RQ5] [RQ7] byte position picks the slot
                if (ridx < (cfg.master ? cfg.in_len : nb)) begin
                    in_we = cfg.in_en;
                end else if (!cfg.master) begin
                    fwd_set = 1'b1;
                end
            end
            if (rxo[0].fend) begin
                next_wcnt   = '0;
                next_rx_act = 1'b1;
                if (recover) begin
                    next_recover = 1'b0;
                    next_zero_tx = 1'b1;
                end
                // [RQ6] next poll follows at once
                next_st   = cfg.master ? L_SEND : L_RET;
                next_bidx = 8'h00;
            end
            // [RQ12] mixed chain shuts the link down
            if (tmo_hit && cfg.strict) begin
                next_running = 1'b0;
                next_st      = L_IDLE;
            end
        end

        // [RQ3] all out_len bytes of the output image in one frame
        if (running && st == L_SEND && !tx_busy[0]) begin
            if (bidx < cfg.out_len) begin
                tx_go[0]  = 1'b1;
                tx_data[0] = zero_tx ? 8'h00 : lane(out_img[bidx[6:2]], bidx[1:0]);
                next_bidx = bidx + 1'b1;
            end else begin
                next_st      = L_WAIT;
                next_ridx    = 8'h00;
                next_zero_tx = 1'b0;
            end
        end

        // [RQ4] own data leads, downstream returns follow
        if (running && !cfg.master && !tx_busy[0]) begin
            if (st == L_RET && bidx < nb) begin
                tx_go[0]   = 1'b1;
                tx_data[0] = zero_tx ? 8'h00 : lane(out_img[bidx[4:2]], bidx[1:0]);
                next_bidx  = bidx + 1'b1;
            end else if (rpend) begin
                tx_go[0]   = 1'b1;
                tx_data[0] = rbyte;
                next_rpend = 1'b0;
            end
            if (st == L_RET && bidx >= nb) begin
                next_st      = L_WAIT;
                next_ridx    = 8'h00;
                next_zero_tx = 1'b0;
            end
        end

        if (running && !cfg.master && fpend && !tx_busy[1]) begin
            tx_go[1]   = 1'b1;
            next_fpend = 1'b0;
        end
        // [RQ10] forward pass only while this device runs
        if (running && fwd_set) begin
            next_fpend = 1'b1;
            next_fbyte = rxo[0].data;
        end
        if (running && !cfg.master && rxo[1].vld) begin
            next_rpend = 1'b1;
            next_rbyte = rxo[1].data;
        end

        if (wr && addr == A_CFG) begin
            next_cfg.master = wdata[CFG_MASTER];
            next_cfg.size64 = wdata[CFG_SIZE64];
            next_cfg.in_en  = wdata[CFG_IN_EN];
            next_cfg.out_en = wdata[CFG_OUT_EN];
            next_cfg.strict = wdata[CFG_STRICT];
            next_cfg_set    = 1'b1;
        end
        if (wr && addr == A_LEN) begin
            next_cfg.out_len = wdata[LEN_OUT +: 8];
            next_cfg.in_len  = wdata[LEN_IN +: 8];
        end
        if (wr && addr == A_TMO) begin
            next_tmo = wdata[TCW-1:0];
        end
        // [RQ19] stop freezes the link in place
        if (stop) begin
            next_running = 1'b0;
            next_st      = L_IDLE;
        end
        // [RQ14] [RQ13] [RQ17] start or restart
        if (start) begin
            next_cfg_bad = !cfg_ok;
            next_running = cfg_ok;
            next_st      = !cfg_ok ? L_IDLE : (cfg.master ? L_SEND : L_WAIT);
            next_bidx    = 8'h00;
            next_ridx    = 8'h00;
            next_wcnt    = '0;
            next_fault   = tmo_hit;
            next_recover = 1'b1;
            next_zero_tx = 1'b0;
            next_fpend   = 1'b0;
            next_rpend   = 1'b0;
        end

        next_rdata = 32'h0000_0000;
        if (rd) begin
            case (addr)
                A_CFG:   next_rdata = {27'h0, cfg.strict, cfg.out_en, cfg.in_en,
                                       cfg.size64, cfg.master};
                A_LEN:   next_rdata = {16'h0, cfg.in_len, cfg.out_len};
                A_TMO:   next_rdata = {8'h0, tmo};
                // [RQ20] health, receiving and fault
                A_STAT:  next_rdata = {26'h0, cfg_set, running, cfg_bad, fault, rx_act,
                                       running & !fault & !cfg_bad};
                default: begin
                    if (addr[7:5] == W_OUT) begin
                        next_rdata = out_img[addr[4:0]];
                    end else if (addr[7:5] == W_IN) begin
                        next_rdata = in_img[addr[4:0]];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cfg     <= '{strict: CFG_RST[CFG_STRICT], out_en: CFG_RST[CFG_OUT_EN],
                         in_en: CFG_RST[CFG_IN_EN], size64: CFG_RST[CFG_SIZE64],
                         master: CFG_RST[CFG_MASTER], in_len: LEN_RST, out_len: LEN_RST};
            st      <= L_IDLE;
            tmo     <= TCW'(TMO_DEF);
            wcnt    <= '0;
            bidx    <= 8'h00;
            ridx    <= 8'h00;
            running <= 1'b0;
            cfg_bad <= 1'b0;
            cfg_set <= 1'b0;
            fault   <= 1'b0;
            rx_act  <= 1'b0;
            recover <= 1'b1;
            zero_tx <= 1'b0;
            fpend   <= 1'b0;
            fbyte   <= 8'h00;
            rpend   <= 1'b0;
            rbyte   <= 8'h00;
            rdata   <= 32'h0000_0000;
        end else begin
            cfg     <= next_cfg;
            st      <= next_st;
            tmo     <= next_tmo;
            wcnt    <= next_wcnt;
            bidx    <= next_bidx;
            ridx    <= next_ridx;
            running <= next_running;
            cfg_bad <= next_cfg_bad;
            cfg_set <= next_cfg_set;
            fault   <= next_fault;
            rx_act  <= next_rx_act;
            recover <= next_recover;
            zero_tx <= next_zero_tx;
            fpend   <= next_fpend;
            fbyte   <= next_fbyte;
            rpend   <= next_rpend;
            rbyte   <= next_rbyte;
            rdata   <= next_rdata;
        end
    end

    // [RQ8] [RQ18] images change only on enabled updates, except the input image zeroing on recovery, which in_en does not gate
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 32; i++) begin
                out_img[i] <= 32'h0000_0000;
                in_img[i]  <= 32'h0000_0000;
            end
        end else begin
            if (wr && addr[7:5] == W_OUT && cfg.out_en) begin
                out_img[addr[4:0]] <= wdata;
            end
            if (in_clr) begin
                for (int i = 0; i < 32; i++) begin
                    in_img[i] <= 32'h0000_0000;
                end
            end
            if (in_we) begin
                in_img[in_idx[6:2]][8*in_idx[1:0] +: 8] <= in_byte;
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence start_bit_s;
        !up_tx_p ##BITD !up_tx_p;
    endsequence

    tx_pair_a: assert property (up_tx_n == !up_tx_p && dn_tx_n == !dn_tx_p) // [RQ15]
        else $error("transmit pair not complementary");
    bit_time_a: assert property ($rose(tx_busy[0]) |-> start_bit_s) // [RQ16]
        else $error("start bit shorter than least bit time");
    cfg_gate_a: assert property (start && !cfg_ok |=> !running && cfg_bad) // [RQ14]
        else $error("link started with invalid configuration");
    freeze_a: assert property (in_we |-> running && st == L_WAIT) // [RQ8]
        else $error("input image written while link frozen");
    one_frame_a: assert property ($past(st) == L_SEND && st == L_WAIT && running
                                  |-> $past(bidx) == cfg.out_len) // [RQ3]
        else $error("master frame ended before all outputs");
    slave_take_a: assert property (running && !cfg.master && st == L_WAIT && rxo[0].vld
                                   |-> fwd_set == (ridx >= nb)) // [RQ5]
        else $error("slave share or forward wrong");
    poll_a: assert property (running && cfg.master && st == L_WAIT && rxo[0].fend && !stop
                             && !start |=> st == L_SEND ##[0:2] tx_go[0]) // [RQ6]
        else $error("master did not poll again");
    timeout_a: assert property (running && st == L_WAIT && wcnt >= tmo && !rxo[0].fend
                                |=> !rx_act && fault) // [RQ21]
        else $error("receive timeout not flagged");
    recover_a: assert property (running && st == L_WAIT && recover && rxo[0].vld
                                && ridx == 8'h00 |-> in_clr) // [RQ9]
        else $error("input image not zeroed on recovery");
    slot_a: assert property (in_we && cfg.master |-> in_idx < cfg.in_len) // [RQ7]
        else $error("input slot beyond configured length");
endmodule

// ### sim/link_partner.sv
module link_partner (
    input  wire logic        mclk,     // System clock
    input  wire logic        tx_p,     // Line from the master, true
    input  wire logic        reply_en, // Answer polls when high
    input  wire logic [15:0] reply,    // Two bytes to return
    output logic             rx_p,     // Line to the master, true
    output logic             rx_n,     // Line to the master, complement
    output logic [7:0]       got,      // Last byte received
    output int               nfr       // Polls seen
);
    timeunit 1ns;
    timeprecision 1ps;

    assign rx_n = ~rx_p;

    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_p <= f[i];
            repeat (27) @(posedge mclk);
        end
    endtask

    initial begin
        rx_p = 1'b1;
        got = 8'h00;
        nfr = 0;
        forever begin
            @(negedge tx_p);
            repeat (40) @(posedge mclk);
            for (int i = 0; i < 8; i++) begin
                got[i] = tx_p;
                repeat (27) @(posedge mclk);
            end
            // Wait past the idle gap that closes the poll
            repeat (600) @(posedge mclk);
            nfr++;
            if (reply_en) begin
                send(reply[7:0]);
                send(reply[15:8]);
            end
        end
    end
endmodule

// ### sim/tb.sv
module tb;
    import lnk_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic        tx_p, tx_n, rx_p, rx_n, dtx_p, dtx_n, ren = 1'b1;
    logic [7:0]  got;
    logic [31:0] v;
    int          nfr;
    int          fail_count = 0;
    int          tests_run = 0;

    always #12.5 mclk = ~mclk;

    io_link_engine #(.TMO_DEF(2000)) i_dut (
        .mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .up_rx_p(rx_p), .up_rx_n(rx_n), .up_tx_p(tx_p), .up_tx_n(tx_n),
        .dn_rx_p(1'b1), .dn_rx_n(1'b0), .dn_tx_p(dtx_p), .dn_tx_n(dtx_n));

    link_partner i_far (.mclk(mclk), .tx_p(tx_p), .reply_en(ren), .reply(16'h2211),
        .rx_p(rx_p), .rx_n(rx_n), .got(got), .nfr(nfr));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s: got %h want %h", $time, m, seen, exp);
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic polls(input int n);
        int t;
        t = nfr + n;
        for (int k = 0; k < 20000 && nfr < t; k++) @(posedge mclk);
        check(nfr >= t, 1'b1, "poll limit");
    endtask

    task automatic t_reset;
        rreg(A_CFG, v); check(v, 32'h0c, "cfg");
        rreg(A_LEN, v); check(v, 32'h8080, "len");
        rreg(A_TMO, v); check(v, 32'h7d0, "tmo");
        rreg(8'h10, v); check(v, 32'h0, "unmapped");
        wreg(A_CTRL, 32'h1);
        rreg(A_STAT, v); check(v, 32'h08, "badcfg");
        $display("test reset done");
    endtask

    task automatic t_run;
        wreg(A_CFG, 32'h0d);
        wreg(A_LEN, 32'h0201);
        wreg(8'h40, 32'ha5);
        wreg(A_CTRL, 32'h1);
        polls(4);
        check(got, 8'ha5, "out byte");
        rreg(8'h80, v); check(v, 32'h2211, "inputs");
        rreg(A_STAT, v); check(v, 32'h33, "stat");
        $display("test run done");
    endtask

    task automatic t_fault;
        ren <= 1'b0;
        polls(2);
        rreg(A_STAT, v); check(v & 32'h6, 32'h4, "tmo");
        rreg(8'h80, v); check(v, 32'h2211, "hold");
        ren <= 1'b1;
        polls(2);
        check(got, 8'h00, "zero frame");
        polls(1);
        rreg(8'h80, v); check(v, 32'h2211, "recover");
        check(nfr > 6, 1'b1, "repoll");
        wreg(A_CTRL, 32'h2);
        repeat (1200) @(posedge mclk);
        rreg(A_STAT, v); check(v[4], 1'b0, "stopped");
        check({tx_p, tx_n}, 2'b10, "idle");
        check({dtx_p, dtx_n}, 2'b10, "lower idle");
        ren <= 1'b0;
        wreg(A_CFG, 32'h1d);
        wreg(A_CTRL, 32'h1);
        rreg(A_STAT, v); check(v & 32'h14, 32'h10, "restart");
        repeat (2600) @(posedge mclk);
        rreg(A_STAT, v); check(v & 32'h14, 32'h04, "strict stop");
        $display("test fault done");
    endtask

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        #(25 * 90000);
        fail_count++;
        end_sim;
    end

    initial begin
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        t_reset;
        t_run;
        t_fault;
        end_sim;
    end
endmodule
